// ### rtl/timer_pkg.sv
// Overview of operation
// [RULE1] Hidden 8-bit counter 1, steps every 32 clocks.
// [RULE2] Counter 1 wraps after F9h; wrap is overflow.
// [RULE3] Period select doubles timebase from 8000 to 16000.
// [RULE4] Counter 1 overflow sets flag; enabled flag requests interrupt.
// [RULE5] Timebase-1 flag clears only by reading register one.
// [RULE6] Readable 8-bit counter 2 starts from reload value.
// [RULE7] Counter 2 reloads after FFh; new reload waits.
// [RULE8] Counter 2 overflow sets flag; register two read clears.
// [RULE9] Any capture pin edge copies counter 1, sets flag.
// [RULE10] Capture request while flag and enable; capture read clears.
// [RULE11] Writes never change the capture flag.
// [RULE12] Edges ignored while capture flag is set.
// [RULE13] Capture register read-only, resets to 00h.
// [RULE14] Register one layout: enables, flags, period select.
// [RULE15] Register one reads zero after reset.
// [RULE16] Counter 2 register read-only, live value, resets 00h.
// [RULE17] Event in read cycle keeps its flag set.
// [RULE18] Capture pin synchronised; one edge per transition.
`default_nettype none
package timer_pkg;
    localparam int DATA_W = 32;
    localparam int OSC_PER_STEP = 32;
    localparam logic [4:0] PRE_LAST = 5'(OSC_PER_STEP - 1);
    localparam int TB_PERIOD_OSC = 8000;
    localparam int TB_STEPS = TB_PERIOD_OSC / OSC_PER_STEP;
    localparam logic [7:0] C1_TOP = 8'hF9;
    localparam logic [7:0] C2_TOP = 8'hFF;
    localparam logic [7:0] A_CSR1 = 8'h00;
    localparam logic [7:0] A_CNT2 = 8'h04;
    localparam logic [7:0] A_CAP = 8'h08;
    localparam logic [7:0] A_CSR2 = 8'h0C;
    localparam logic [7:0] A_RELOAD = 8'h10;
    localparam logic [7:0] A_ISTAT = 8'h14;
    localparam logic [7:0] A_ICLR = 8'h18;
    localparam logic [7:0] A_IEN = 8'h1C;
    localparam int B_CAP_IE = 7;
    localparam int B_CAP_FLAG = 6;
    localparam int B_PERIOD = 5;
    localparam int B_TB1_IE = 4;
    localparam int B_TB1_FLAG = 3;
    localparam int B_TB2_IE = 1;
    localparam int B_TB2_FLAG = 0;
    localparam int EV_W = 3;
    localparam logic [7:0] BYTE_RST = 8'h00;
    localparam logic [EV_W-1:0] EV_RST = 3'h0;
    typedef struct packed {
        logic cap_ie;
        logic period_sel;
        logic tb1_ie;
        logic tb2_ie;
    } ctrl_s;
    localparam ctrl_s CTRL_RST = '{cap_ie: 1'b0, period_sel: 1'b0, tb1_ie: 1'b0, tb2_ie: 1'b0};
    typedef struct packed {
        logic valid;
        logic write;
        logic [7:0] addr;
    } bus_req_s;
    localparam bus_req_s REQ_RST = '{valid: 1'b0, write: 1'b0, addr: 8'h00};
endpackage
`default_nettype wire

// ### rtl/timebase_capture_timer.sv
// Register access over AHB-Lite and the register offsets were left to the implementer.
`default_nettype none
module timebase_capture_timer (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [timer_pkg::DATA_W-1:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [timer_pkg::DATA_W-1:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [timer_pkg::DATA_W-1:0] hrdata,
    input wire logic capture_input_pin,
    output logic tb1_irq,
    output logic tb2_irq,
    output logic capture_irq,
    output logic irq
);
    import timer_pkg::*;

    logic [4:0] pre_q, pre_d;
    logic tick;
    logic [7:0] c1_q, c1_d, c2_q, c2_d;
    logic half_q, half_d;
    logic c1_wrap, c2_wrap, tb1_event, tb2_event;
    logic s1_q, s2_q, s3_q, lvl_q, s1_d, s2_d, s3_d, lvl_d;
    logic pin_edge, cap_take;
    bus_req_s dph_q, dph_d;
    logic acc, rd_acc, wr_en;
    logic [7:0] rd_addr, wdat;
    ctrl_s ctrl_q, ctrl_d;
    logic [7:0] reload_q, reload_d, capture_q, capture_d;
    logic tb1_flag_q, tb1_flag_d, tb2_flag_q, tb2_flag_d, cap_flag_q, cap_flag_d;
    logic [EV_W-1:0] istat_q, istat_d, ien_q, ien_d, events;
    logic [DATA_W-1:0] hrdata_q, hrdata_d;
    logic [7:0] rbyte;

    // Shared prescaler divides the clock by 32 for both counters.
    always_comb begin
        pre_d = pre_q + 5'h01;
        tick = (pre_q == PRE_LAST); // [RULE1]
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pre_q <= 5'h00;
        end else begin
            pre_q <= pre_d;
        end
    end

    // Counter 1 runs 0..F9h; a half-period toggle stretches the event when doubled.
    always_comb begin
        c1_wrap = tick && (c1_q == C1_TOP); // [RULE2]
        c1_d = c1_q;
        if (tick) begin
            c1_d = c1_wrap ? 8'h00 : c1_q + 8'h01; // [RULE1] [RULE2]
        end
        half_d = c1_wrap ? ~half_q : half_q;
        tb1_event = c1_wrap && (!ctrl_q.period_sel || half_q); // [RULE3]
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            c1_q <= 8'h00;
            half_q <= 1'b0;
        end else begin
            c1_q <= c1_d;
            half_q <= half_d;
        end
    end

    // Counter 2 counts up and takes the reload value as it passes FFh.
    always_comb begin
        c2_wrap = tick && (c2_q == C2_TOP);
        tb2_event = c2_wrap; // [RULE8]
        c2_d = c2_q;
        if (tick) begin
            c2_d = c2_wrap ? reload_q : c2_q + 8'h01; // [RULE6] [RULE7]
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            c2_q <= BYTE_RST; // [RULE16]
        end else begin
            c2_q <= c2_d;
        end
    end

    // Three-stage synchroniser; a level is accepted once stages two and three agree.
    always_comb begin
        s1_d = capture_input_pin;
        s2_d = s1_q;
        s3_d = s2_q;
        lvl_d = (s2_q == s3_q) ? s3_q : lvl_q; // [RULE18]
        pin_edge = (s2_q == s3_q) && (s3_q != lvl_q); // [RULE18]
        cap_take = pin_edge && !cap_flag_q; // [RULE9] [RULE12]
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
            lvl_q <= 1'b0;
        end else begin
            s1_q <= s1_d;
            s2_q <= s2_d;
            s3_q <= s3_d;
            lvl_q <= lvl_d;
        end
    end

    // Bus slave: address phase is latched, writes land in the data phase.
    always_comb begin
        acc = hsel && htrans[1] && hready;
        rd_acc = acc && !hwrite;
        rd_addr = haddr[7:0];
        dph_d = REQ_RST;
        if (acc) begin
            dph_d = '{valid: 1'b1, write: hwrite, addr: haddr[7:0]};
        end
        wr_en = dph_q.valid && dph_q.write;
        wdat = hwdata[7:0];
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dph_q <= REQ_RST;
        end else begin
            dph_q <= dph_d;
        end
    end

    // Software registers and flags; timer flags ignore written values, istat bits clear on ICLR writes of ones.
    always_comb begin
        ctrl_d = ctrl_q;
        reload_d = reload_q;
        ien_d = ien_q;
        istat_d = istat_q;
        if (wr_en) begin
            case (dph_q.addr)
                A_CSR1: begin
                    ctrl_d.cap_ie = wdat[B_CAP_IE]; // [RULE14]
                    ctrl_d.period_sel = wdat[B_PERIOD]; // [RULE3]
                    ctrl_d.tb1_ie = wdat[B_TB1_IE];
                end
                A_CSR2: begin
                    ctrl_d.tb2_ie = wdat[B_TB2_IE];
                end
                A_RELOAD: begin
                    reload_d = wdat; // [RULE7]
                end
                A_IEN: begin
                    ien_d = wdat[EV_W-1:0];
                end
                A_ICLR: begin
                    istat_d = istat_q & ~wdat[EV_W-1:0];
                end
                default: begin
                    ctrl_d = ctrl_q;
                end
            endcase
        end
        events = {cap_take, tb2_event, tb1_event};
        istat_d = istat_d | events;
        tb1_flag_d = tb1_event | (tb1_flag_q & !(rd_acc && rd_addr == A_CSR1)); // [RULE5] [RULE17]
        tb2_flag_d = tb2_event | (tb2_flag_q & !(rd_acc && rd_addr == A_CSR2)); // [RULE8] [RULE17]
        cap_flag_d = cap_take | (cap_flag_q & !(rd_acc && rd_addr == A_CAP)); // [RULE10] [RULE11]
        capture_d = cap_take ? c1_q : capture_q; // [RULE9]
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_q <= CTRL_RST; // [RULE15]
            reload_q <= BYTE_RST;
            ien_q <= EV_RST;
            istat_q <= EV_RST;
            tb1_flag_q <= 1'b0;
            tb2_flag_q <= 1'b0;
            cap_flag_q <= 1'b0;
            capture_q <= BYTE_RST; // [RULE13]
        end else begin
            ctrl_q <= ctrl_d;
            reload_q <= reload_d;
            ien_q <= ien_d;
            istat_q <= istat_d;
            tb1_flag_q <= tb1_flag_d;
            tb2_flag_q <= tb2_flag_d;
            cap_flag_q <= cap_flag_d;
            capture_q <= capture_d;
        end
    end

    // Read data is captured in the address phase, using freshly written controls.
    always_comb begin
        rbyte = 8'h00;
        case (rd_addr)
            A_CSR1: begin
                rbyte[B_CAP_IE] = ctrl_d.cap_ie; // [RULE14]
                rbyte[B_CAP_FLAG] = cap_flag_q;
                rbyte[B_PERIOD] = ctrl_d.period_sel;
                rbyte[B_TB1_IE] = ctrl_d.tb1_ie;
                rbyte[B_TB1_FLAG] = tb1_flag_q;
            end
            A_CNT2: rbyte = c2_q; // [RULE16]
            A_CAP: rbyte = capture_q; // [RULE13]
            A_CSR2: begin
                rbyte[B_TB2_IE] = ctrl_d.tb2_ie;
                rbyte[B_TB2_FLAG] = tb2_flag_q;
            end
            A_RELOAD: rbyte = reload_d;
            A_ISTAT: rbyte = {5'h00, istat_q};
            A_IEN: rbyte = {5'h00, ien_d};
            default: rbyte = 8'h00;
        endcase
        hrdata_d = rd_acc ? {24'h000000, rbyte} : hrdata_q;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_q <= 32'h00000000;
        end else begin
            hrdata_q <= hrdata_d;
        end
    end

    assign hrdata = hrdata_q;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign tb1_irq = tb1_flag_q && ctrl_q.tb1_ie; // [RULE4]
    assign tb2_irq = tb2_flag_q && ctrl_q.tb2_ie; // [RULE8]
    assign capture_irq = cap_flag_q && ctrl_q.cap_ie; // [RULE10]
    assign irq = |(istat_q & ien_q);

    // Checks on the timer behaviour.
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    AST_PRE_SPACING: assert property (tick |=> !tick [*8]) // [RULE1]
        else $error("Prescaler tick came too soon.");
    AST_C1_HOLD: assert property (!tick |=> $stable(c1_q)) // [RULE1]
        else $error("Counter 1 moved without a tick.");
    AST_C1_WRAP: assert property (tick && c1_q == 8'hF9 |=> c1_q == 8'h00) // [RULE2]
        else $error("Counter 1 did not wrap after F9h.");
    AST_PERIOD: assert property (c1_wrap && ctrl_q.period_sel && !half_q |-> !tb1_event) // [RULE3]
        else $error("Doubled period raised an early event.");
    AST_TB1_SET: assert property (tb1_event |=> tb1_flag_q ##0 (tb1_irq == ctrl_q.tb1_ie)) // [RULE4]
        else $error("Timebase 1 flag or request missing.");
    AST_TB1_KEEP: assert property (tb1_flag_q && !(rd_acc && rd_addr == A_CSR1) |=> tb1_flag_q) // [RULE5]
        else $error("Timebase 1 flag lost without a read.");
    AST_C2_RELOAD: assert property (c2_wrap |=> c2_q == $past(reload_q)) // [RULE7]
        else $error("Counter 2 did not reload.");
    AST_TB2_CLR: assert property (rd_acc && rd_addr == A_CSR2 && !tb2_event |=> !tb2_flag_q) // [RULE8]
        else $error("Timebase 2 flag survived its read.");
    AST_CAP_TAKE: assert property (cap_take |=> cap_flag_q && capture_q == $past(c1_q)) // [RULE9]
        else $error("Capture did not latch counter 1.");
    AST_CAP_LOCK: assert property (cap_flag_q && !(rd_acc && rd_addr == A_CAP) |=>
        $stable(capture_q) && cap_flag_q) // [RULE12]
        else $error("Capture changed while its flag was set.");
    AST_RACE: assert property (tb1_event && rd_acc && rd_addr == A_CSR1 |=> tb1_flag_q) // [RULE17]
        else $error("Event lost in its read cycle.");
    AST_CNT_READ: assert property (rd_acc && rd_addr == A_CNT2 |=> hrdata == {24'h0, $past(c2_q)}) // [RULE16]
        else $error("Counter 2 read returned a wrong value.");

    COV_TB1: cover property (tb1_event ##1 tb1_irq);
    COV_TB2: cover property (tb2_event ##1 tb2_flag_q);
    COV_CAP: cover property (cap_take ##1 capture_irq);
    COV_CAP_IGNORED: cover property (pin_edge && cap_flag_q);
endmodule
`default_nettype wire

// ### tb/testbench.sv
`default_nettype none
module testbench;
    import timer_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;
    typedef struct packed {
        logic w;
        logic [7:0] a;
        logic [7:0] d;
        logic [7:0] e;
    } row_s;
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, pin;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic tb1_irq, tb2_irq, capture_irq, irq;
    int fail_count = 0;
    int cmp_count = 0;
    int cyc = 0;
    int t0, t1;
    row_s rows [21] = '{
        '{1'b0, A_CNT2, 8'h00, 8'h00}, '{1'b0, A_CSR1, 8'h00, 8'h00},
        '{1'b0, A_CAP, 8'h00, 8'h00}, '{1'b0, A_CSR2, 8'h00, 8'h00},
        '{1'b0, A_RELOAD, 8'h00, 8'h00}, '{1'b0, A_ISTAT, 8'h00, 8'h00},
        '{1'b0, A_IEN, 8'h00, 8'h00}, '{1'b0, 8'h20, 8'h00, 8'h00},
        '{1'b1, A_CSR1, 8'hFF, 8'h00}, '{1'b0, A_CSR1, 8'h00, 8'hB0},
        '{1'b1, A_CSR1, 8'h10, 8'h00}, '{1'b1, A_CSR2, 8'hFF, 8'h00},
        '{1'b0, A_CSR2, 8'h00, 8'h02}, '{1'b1, A_RELOAD, 8'hF0, 8'h00},
        '{1'b0, A_RELOAD, 8'h00, 8'hF0}, '{1'b1, A_CAP, 8'hFF, 8'h00},
        '{1'b0, A_CAP, 8'h00, 8'h00}, '{1'b1, A_IEN, 8'h04, 8'h00},
        '{1'b0, A_IEN, 8'h00, 8'h04}, '{1'b1, A_ICLR, 8'h07, 8'h00},
        '{1'b0, A_ICLR, 8'h00, 8'h00}
    };

    timebase_capture_timer dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .capture_input_pin(pin), .tb1_irq(tb1_irq), .tb2_irq(tb2_irq),
        .capture_irq(capture_irq), .irq(irq));

    initial begin
        hclk = 1'b0;
        forever #12.5 hclk = ~hclk;
    end

    always @(posedge hclk) cyc <= cyc + 1;

    task automatic close_out();
        if (fail_count == 0 && cmp_count > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
            output logic [31:0] r);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {24'h000000, a};
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        r = hrdata;
        chk("hresp", 32'(hresp), 32'h0);
        #1;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d, rd);
    endtask

    task automatic rchk(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0, rd);
        chk($sformatf("reg %h", a), rd, e);
    endtask

    function automatic logic pick(input int s);
        case (s)
            0: return tb1_irq;
            1: return tb2_irq;
            default: return capture_irq;
        endcase
    endfunction

    task automatic wait_hi(input int s, input int lim);
        int n;
        n = 0;
        while (pick(s) !== 1'b1 && n < lim) begin
            @(posedge hclk);
            #1;
            n++;
        end
        chk($sformatf("irq line %0d", s), 32'(pick(s)), 32'h1);
    endtask

    initial begin
        repeat (80000) @(posedge hclk);
        fail_count++;
        close_out();
    end

    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        pin = 1'b0;
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        foreach (rows[i]) begin
            bus(rows[i].w, rows[i].a, {24'h0, rows[i].d}, rd);
            if (!rows[i].w) chk($sformatf("row %0d", i), rd, {24'h0, rows[i].e});
        end
        wait_hi(1, 9000);
        rchk(A_CNT2, 32'hF0);
        rchk(A_CSR2, 32'h03);
        chk("tb2_irq", 32'(tb2_irq), 32'h0);
        wr(A_RELOAD, 32'h80);
        bus(1'b0, A_CNT2, 32'h0, rd);
        chk("cnt2 hold", 32'(rd[7:4] == 4'hF), 32'h1);
        wait_hi(1, 600);
        rchk(A_CNT2, 32'h80);
        wr(A_CSR2, 32'h0);
        rchk(A_CSR1, 32'h18);
        chk("tb1_irq", 32'(tb1_irq), 32'h0);
        wait_hi(0, 9000);
        t0 = cyc;
        bus(1'b0, A_CSR1, 32'h0, rd);
        wait_hi(0, 9000);
        t1 = cyc;
        chk("period 1x", 32'(t1 - t0), 32'h1F40);
        wr(A_CSR1, 32'h98);
        chk("tb1 kept", 32'(tb1_irq), 32'h1);
        while (cyc < t1 + 328) @(posedge hclk);
        pin <= 1'b1;
        wait_hi(2, 12);
        chk("irq", 32'(irq), 32'h1);
        repeat (64) @(posedge hclk);
        pin <= 1'b0;
        repeat (8) @(posedge hclk);
        wr(A_CSR1, 32'h90);
        chk("cap kept", 32'(capture_irq), 32'h1);
        rchk(A_CSR1, 32'hD8);
        rchk(A_CAP, 32'h0A);
        chk("cap_irq", 32'(capture_irq), 32'h0);
        chk("irq sticky", 32'(irq), 32'h1);
        wr(A_ICLR, 32'h04);
        chk("irq clear", 32'(irq), 32'h0);
        wr(A_IEN, 32'h0);
        @(posedge hclk);
        pin <= 1'b1;
        wait_hi(2, 12);
        chk("irq masked", 32'(irq), 32'h0);
        bus(1'b0, A_CAP, 32'h0, rd);
        wr(A_CSR1, 32'h30);
        bus(1'b0, A_CSR1, 32'h0, rd);
        wait_hi(0, 17000);
        t0 = cyc;
        bus(1'b0, A_CSR1, 32'h0, rd);
        wait_hi(0, 17000);
        chk("period 2x", 32'(cyc - t0), 32'h3E80);
        @(posedge hclk);
        hresetn <= 1'b0;
        pin <= 1'b0;
        repeat (5) @(posedge hclk);
        chk("reset rdata", hrdata, 32'h0);
        chk("reset irq", 32'(irq | tb1_irq | capture_irq), 32'h0);
        hresetn <= 1'b1;
        rchk(A_CSR1, 32'h0);
        rchk(A_CAP, 32'h0);
        close_out();
    end
endmodule
`default_nettype wire
